// [logic/npic_core.sv]
// Purpose: Nested interrupt controller: levels, arbitration, latching.
// Assumes: Core reports instruction ends and level-affecting opcodes.
// Notes:   All state is one packed struct registered in one process.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps

module npic_core
   import npic_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   input  wire logic [3:0]       addr,
   input  wire logic [7:0]       wdata,
   input  wire logic             wr,
   input  wire logic             rd,
   output logic      [7:0]       rdata,
   input  wire npic_cpu_s        cpu,
   input  wire logic             insn_end,
   input  wire logic [NPIN-1:0]  ext_pin,
   input  wire logic [NVEC-1:0]  periph_flag,
   input  wire logic [NVEC-1:0]  periph_en,
   input  wire logic [NVEC-1:0]  periph_clr,
   output npic_take_s            take,
   output logic      [7:0]       cpu_codes,
   output logic                  jump_masked,
   output logic                  jump_not_masked,
   output logic                  halted,
   output logic                  waiting
);

   ////////////////////////////////////////////////////////////////////
   // State record.
   ////////////////////////////////////////////////////////////////////

   // Everything the block remembers.
   typedef struct packed {
      npic_state_e      fsm;
      logic [7:0]       codes;
      logic [3:0][7:0]  prio;
      logic [15:0]      sel;
      logic [NVEC-1:0]  pend;
      logic             trap;
      logic [NPIN-1:0]  s1;
      logic [NPIN-1:0]  s2;
      logic [NPIN-1:0]  s3;
      logic [NPIN-1:0]  flt;
      npic_take_s       take;
      logic [7:0]       rdata;
      logic             jm;
      logic             jnm;
   } npic_regs_s;

   npic_regs_s       r;        // Registered state.
   npic_regs_s       next_r;   // Next state.
   logic [NPIN-1:0]  hit;      // Selected pin rising edges.
   logic [NVEC-1:0]  ext_set;  // External line events.
   logic [NVEC-1:0]  per_set;  // Peripheral requests.
   logic [NVEC-1:0]  cand;     // Candidates for arbitration.
   logic [4:0]       win;      // Found flag and winner index.
   logic [1:0]       cur;      // Current level after this cycle's op.
   logic             go;       // Service point reached.

   ////////////////////////////////////////////////////////////////////
   // Helpers.
   ////////////////////////////////////////////////////////////////////

   // Orders level codes: level 0 gives 0, level 3 gives 3.
   function automatic logic [1:0] rank(input logic [1:0] l);
      rank = {~(l[1] ^ l[0]), l[0]};
   endfunction : rank

   // Reads the level field out of condition codes.
   function automatic logic [1:0] lvl_of(input logic [7:0] c);
      lvl_of = {c[LVL_HI_BIT], c[LVL_LO_BIT]};
   endfunction : lvl_of

   // Returns the priority pair of vector v.
   function automatic logic [1:0] pair_of(input logic [3:0][7:0] p,
                                          input logic [3:0] v);
      pair_of = p[v[3:2]][{v[1:0], 1'b0} +: 2];
   endfunction : pair_of

   // Merges a register write, keeping pairs written with level 0.
   function automatic logic [7:0] merge(input logic [7:0] o,
                                        input logic [7:0] n);
      logic [7:0] m;
      m = n;
      for (int k = 0; k < 4; k++)
      begin
         if (n[2*k +: 2] == LVL0)
         begin
            m[2*k +: 2] = o[2*k +: 2];
         end
      end
      merge = m;
   endfunction : merge

   // Picks the best candidate above level c; ties go to low pairs.
   function automatic logic [4:0] pick(input logic [NVEC-1:0] q,
                                       input logic [3:0][7:0] p,
                                       input logic [1:0] c);
      logic       f;
      logic [3:0] b;
      logic [1:0] br;
      logic [1:0] vr;
      f  = 1'b0;
      b  = 4'h0;
      br = 2'h0;
      for (int i = NVEC - 1; i >= 0; i--)
      begin
         vr = rank(pair_of(p, 4'(i)));
         if (q[i] && vr > rank(c) && (!f || vr >= br))
         begin
            f  = 1'b1;
            b  = 4'(i);
            br = vr;
         end
      end
      pick = {f, b};
   endfunction : pick

   ////////////////////////////////////////////////////////////////////
   // Next-state logic.
   ////////////////////////////////////////////////////////////////////

   // Computes the whole next state in one pass.
   always_comb
   begin
      next_r = r;
      hit = '0;
      ext_set = '0;
      per_set = '0;
      cand = '0;
      win = '0;
      cur = '0;
      go = 1'b0;
      next_r.take.valid = 1'b0;
      next_r.rdata = 8'h00;

      // Pins pass three flops; a level counts once two agree.
      next_r.s1 = ext_pin;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      for (int i = 0; i < NPIN; i++)
      begin
         if (r.s2[i] == r.s3[i])
         begin
            next_r.flt[i] = r.s3[i];
         end
      end
      hit = next_r.flt & ~r.flt & r.sel;

      for (int g = 0; g < 4; g++)
      begin
         ext_set[EXT_BASE + g] = |hit[4*g +: 4];
      end

      per_set = periph_flag & periph_en & ~EXT_MASK;

      next_r.pend = (r.pend & ~(periph_clr & ~EXT_MASK))
                    | ext_set | per_set;

      // Register reads answer one cycle later.
      if (rd)
      begin
         case (addr)
            ADDR_CODES:   next_r.rdata = r.codes;
            ADDR_SEL_LO:  next_r.rdata = r.sel[7:0];
            ADDR_SEL_HI:  next_r.rdata = r.sel[15:8];
            ADDR_PEND_LO: next_r.rdata = r.pend[7:0];
            ADDR_PEND_HI: next_r.rdata = {2'b00, r.pend[13:8]};
            default:
            begin
               // Priority registers, else unmapped reads zero.
               if (addr >= ADDR_PRIO0 && addr <= ADDR_PRIO3)
               begin
                  next_r.rdata = r.prio[2'(addr - ADDR_PRIO0)];
               end
            end
         endcase
      end

      // Register writes.
      if (wr)
      begin
         case (addr)
            ADDR_CODES:  next_r.codes = wdata | CODES_FIXED;
            ADDR_SEL_LO: next_r.sel[7:0] = wdata;
            ADDR_SEL_HI: next_r.sel[15:8] = wdata;
            default:
            begin
               if (addr >= ADDR_PRIO0 && addr <= ADDR_PRIO3)
               begin
                  next_r.prio[2'(addr - ADDR_PRIO0)] =
                     merge(r.prio[2'(addr - ADDR_PRIO0)], wdata);
               end
               next_r.prio[3] = next_r.prio[3] | PRIO3_ONES;
            end
         endcase
      end

      case (cpu.op)
         OP_ENABLE:
         begin
            next_r.codes[LVL_HI_BIT] = LVL0[1];
            next_r.codes[LVL_LO_BIT] = LVL0[0];
         end
         OP_DISABLE:
         begin
            next_r.codes[LVL_HI_BIT] = LVL3[1];
            next_r.codes[LVL_LO_BIT] = LVL3[0];
         end
         OP_HALT, OP_WAIT:
         begin
            // Sleep opens the level so any source may wake wait and any halt-capable source may wake halt.
            next_r.codes[LVL_HI_BIT] = LVL0[1];
            next_r.codes[LVL_LO_BIT] = LVL0[0];
            next_r.fsm = (cpu.op == OP_HALT) ? ST_HALT : ST_WAIT;
         end
         OP_TRAP: next_r.trap = 1'b1;
         OP_RETURN, OP_POP_CODES: next_r.codes = cpu.data | CODES_FIXED;
         default:
         begin
            // No level change.
         end
      endcase

      cur = lvl_of(next_r.codes);

      cand = (r.fsm == ST_HALT) ? (r.pend & HALT_MASK) : r.pend;
      win = pick(cand, r.prio, cur);

      // Controller sequencing.
      case (r.fsm)
         ST_RESET:
         begin
            next_r.take.valid  = 1'b1;
            next_r.take.stack  = 1'b0;
            next_r.take.vector = VEC_RESET;
            next_r.take.level  = LVL3;
            next_r.codes = CODES_RST;
            next_r.fsm = ST_RUN;
         end
         ST_RUN:
         begin
            go = insn_end;
         end
         ST_HALT, ST_WAIT:
         begin
            go = win[4];
            if (win[4])
            begin
               next_r.fsm = ST_RUN;
            end
         end
         default:
         begin
            next_r.fsm = ST_RESET;
         end
      endcase

      if (go && next_r.trap)
      begin
         next_r.trap = 1'b0;
         next_r.take.valid  = 1'b1;
         next_r.take.stack  = 1'b1;
         next_r.take.vector = VEC_TRAP;
         next_r.take.level  = LVL3;
         next_r.codes[LVL_HI_BIT] = LVL3[1];
         next_r.codes[LVL_LO_BIT] = LVL3[0];
      end
      else if (go && win[4])
      begin
         next_r.take.valid  = 1'b1;
         next_r.take.stack  = 1'b1;
         next_r.take.vector = VEC_PAIR0 - {11'h000, win[3:0], 1'b0};
         next_r.take.level  = pair_of(r.prio, win[3:0]);
         next_r.codes[LVL_HI_BIT] = next_r.take.level[1];
         next_r.codes[LVL_LO_BIT] = next_r.take.level[0];
         if (EXT_MASK[win[3:0]])
         begin
            next_r.pend[win[3:0]] = ext_set[win[3:0]];
         end
      end

      next_r.jm  = (lvl_of(next_r.codes) == LVL3);
      next_r.jnm = (lvl_of(next_r.codes) != LVL3);
   end

   ////////////////////////////////////////////////////////////////////
   // State register.
   ////////////////////////////////////////////////////////////////////

   // Registers the state; reset loads constants only.
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         r       <= '0;
         r.fsm   <= ST_RESET;
         r.codes <= CODES_RST;
         r.prio  <= {4{PRIO_RST}};
         r.sel   <= SEL_RST;
         r.jm    <= 1'b1;
      end
      else
      begin
         r <= next_r;
      end
   end

   // Outputs come straight from the state flops.
   assign rdata           = r.rdata;
   assign take            = r.take;
   assign cpu_codes       = r.codes;
   assign jump_masked     = r.jm;
   assign jump_not_masked = r.jnm;
   assign halted          = r.fsm[2];
   assign waiting         = r.fsm[3];

   ////////////////////////////////////////////////////////////////////
   // Checks.
   ////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   // Reset state issues the reset vector unstacked.
   property p_rst_vec;
      r.fsm == ST_RESET |=> take.valid && !take.stack
                           && take.vector == VEC_RESET && jump_masked;
   endproperty
   a_rst_vec: assert property (p_rst_vec)
      else $error("reset vector not issued");

   // Trap entry stacks and masks everything.
   property p_trap;
      take.valid && take.vector == VEC_TRAP |->
         take.stack && lvl_of(cpu_codes) == LVL3;
   endproperty
   a_trap: assert property (p_trap)
      else $error("trap entry wrong");

   // Maskable entry copies the pair level into the codes.
   property p_entry_lvl;
      take.valid && take.vector <= VEC_PAIR0 |->
         lvl_of(cpu_codes) == take.level;
   endproperty
   a_entry_lvl: assert property (p_entry_lvl)
      else $error("entry level mismatch");

   // Enable instruction in run without entry opens level 0.
   property p_enable;
      cpu.op == OP_ENABLE && r.fsm == ST_RUN && !insn_end
         |=> lvl_of(cpu_codes) == LVL0;
   endproperty
   a_enable: assert property (p_enable)
      else $error("enable did not load level 0");

   // Jump flags track the level field.
   property p_jump;
      jump_masked == (lvl_of(cpu_codes) == LVL3)
         && jump_not_masked != jump_masked;
   endproperty
   a_jump: assert property (p_jump)
      else $error("jump flags wrong");

   // Upper nibble of the last priority register reads ones.
   property p_prio3;
      rd && addr == ADDR_PRIO3 |=> rdata[7:4] == 4'hf;
   endproperty
   a_prio3: assert property (p_prio3)
      else $error("fixed nibble not ones");

   // A level-0 pair write leaves the pair alone.
   property p_keep;
      wr && addr == ADDR_PRIO0 && wdata[1:0] == LVL0
         |=> r.prio[0][1:0] == $past(r.prio[0][1:0]);
   endproperty
   a_keep: assert property (p_keep)
      else $error("level 0 write changed pair");

   // A maskable entry is strictly above the prior level.
   property p_higher;
      take.valid && take.vector <= VEC_PAIR0 |->
         rank(take.level) > rank($past(cur));
   endproperty
   a_higher: assert property (p_higher)
      else $error("entry not above level");

   // Leaving halt serves a halt-capable vector.
   property p_halt;
      take.valid && take.vector <= VEC_PAIR0
         && $past(r.fsm) == ST_HALT |->
         HALT_MASK[4'((VEC_PAIR0 - take.vector) >> 1)];
   endproperty
   a_halt: assert property (p_halt)
      else $error("halt exit by wrong source");

endmodule : npic_core

// [logic/npic_pkg.sv]
// Purpose: Shared constants and types of the nested interrupt controller.
// Assumes: One 25 MHz clock; 8-bit register port; 14 maskable vectors.
// Notes:   Vector pair 0 has the highest fixed hardware priority.
package npic_pkg;

   // Number of maskable vectors and of external pins.
   localparam int NVEC = 14;
   localparam int NPIN = 16;

   // Register offsets on the plain register port.
   localparam logic [3:0] ADDR_CODES   = 4'h0;
   localparam logic [3:0] ADDR_PRIO0   = 4'h1;
   localparam logic [3:0] ADDR_PRIO3   = 4'h4;
   localparam logic [3:0] ADDR_SEL_LO  = 4'h5;
   localparam logic [3:0] ADDR_SEL_HI  = 4'h6;
   localparam logic [3:0] ADDR_PEND_LO = 4'h7;
   localparam logic [3:0] ADDR_PEND_HI = 4'h8;

   // Reset values and fixed bits.
   localparam logic [7:0]  CODES_RST   = 8'hea;
   localparam logic [7:0]  CODES_FIXED = 8'hc0;
   localparam logic [7:0]  PRIO_RST    = 8'hff;
   localparam logic [7:0]  PRIO3_ONES  = 8'hf0;
   localparam logic [15:0] SEL_RST    = 16'hffff;

   // Level field positions inside the condition codes.
   localparam int LVL_HI_BIT = 5;
   localparam int LVL_LO_BIT = 3;

   // Level encodings.
   localparam logic [1:0] LVL0 = 2'b10;
   localparam logic [1:0] LVL3 = 2'b11;

   // Vector addresses of reset, trap and pair 0.
   localparam logic [15:0] VEC_RESET = 16'hfffe;
   localparam logic [15:0] VEC_TRAP  = 16'hfffc;
   localparam logic [15:0] VEC_PAIR0 = 16'hfffa;

   // Vectors fed by external lines, and halt-capable vectors.
   localparam int         EXT_BASE  = 2;
   localparam logic [13:0] EXT_MASK  = 14'h003c;
   localparam logic [13:0] HALT_MASK = 14'h00be;

   // Controller states, one-hot.
   typedef enum logic [3:0] {
      ST_RESET = 4'b0001,
      ST_RUN   = 4'b0010,
      ST_HALT  = 4'b0100,
      ST_WAIT  = 4'b1000
   } npic_state_e;

   // Level-affecting instructions reported by the core.
   typedef enum logic [2:0] {
      OP_NONE  = 3'h0,
      OP_ENABLE    = 3'h1,
      OP_DISABLE   = 3'h2,
      OP_HALT      = 3'h3,
      OP_WAIT      = 3'h4,
      OP_TRAP      = 3'h5,
      OP_RETURN    = 3'h6,
      OP_POP_CODES = 3'h7
   } npic_op_e;

   // Instruction report from the core.
   typedef struct packed {
      npic_op_e   op;
      logic [7:0] data;
   } npic_cpu_s;

   // Service entry order to the core.
   typedef struct packed {
      logic        valid;
      logic        stack;
      logic [15:0] vector;
      logic [1:0]  level;
   } npic_take_s;

endpackage : npic_pkg

// [dv/npic_cpu_model.sv]
// Purpose: Behavioural core that paces instruction ends for the block.
// Assumes: Two-cycle instructions; stall withholds boundaries while busy still counts down.
// Notes:   Every service entry costs a stacking burst with no boundary.
`timescale 1ns/100ps
module npic_cpu_model
   import npic_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       stall,
   input  wire npic_take_s take,
   output logic            insn_end
);
   // Cycles left before the next instruction boundary.
   logic [2:0] busy;

   ////////////////////////////////////////////////////////////////////
   // A boundary is offered only between instructions, never while
   // registers are being pushed after an entry.
   // boundary pacing
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         busy     <= 3'h0;
         insn_end <= 1'b0;
      end
      else if (take.valid)
      begin
         busy     <= 3'h4;
         insn_end <= 1'b0;
      end
      else if (stall || busy != 3'h0)
      begin
         busy     <= (busy == 3'h0) ? 3'h0 : busy - 3'h1;
         insn_end <= 1'b0;
      end
      else
      begin
         busy     <= 3'h1;
         insn_end <= 1'b1;
      end
   end
endmodule : npic_cpu_model

// [dv/npic_core_tb_top.sv]
// Purpose: Self-checking bench of the nested interrupt controller.
// Assumes: The core model paces boundaries; the bench drives the rest.
// Notes:   Register cases run from a table, entries are hand-written.
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
   begin \
      cmp_count++; \
      if ((got) !== (ex)) \
      begin \
         miscompares++; \
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
      end \
   end
module npic_core_tb_top
   import npic_pkg::*;
;
   // One register case: offset, data written, value read back.
   typedef struct packed {
      logic [3:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } npic_row_s;

   logic            ref_clk;
   logic            resetn;
   logic [3:0]      addr;
   logic [7:0]      wdata;
   logic            wr;
   logic            rd;
   logic [7:0]      rdata;
   npic_cpu_s       cpu;
   logic            insn_end;
   logic [NPIN-1:0] ext_pin;
   logic [NVEC-1:0] periph_flag;
   logic [NVEC-1:0] periph_en;
   logic [NVEC-1:0] periph_clr;
   npic_take_s      take;
   logic [7:0]      cpu_codes;
   logic            jump_masked;
   logic            jump_not_masked;
   logic            halted;
   logic            waiting;
   logic            stall;
   int              miscompares;
   int              cmp_count;
   int              i;
   npic_row_s       rows [11] = '{
      '{4'h1, 8'h66, 8'h77}, '{4'h1, 8'hcf, 8'hcf}, '{4'h1, 8'h64, 8'h44},
      '{4'h4, 8'h00, 8'hf0}, '{4'h4, 8'h0a, 8'hf0}, '{4'h2, 8'h5a, 8'h5f},
      '{4'h3, 8'h57, 8'h57}, '{4'hf, 8'h55, 8'h00}, '{4'h7, 8'hff, 8'h00},
      '{4'h0, 8'h08, 8'hc8}, '{4'h0, 8'h20, 8'he0}};

   npic_core dut (
      .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .cpu(cpu), .insn_end(insn_end),
      .ext_pin(ext_pin), .periph_flag(periph_flag),
      .periph_en(periph_en), .periph_clr(periph_clr), .take(take),
      .cpu_codes(cpu_codes), .jump_masked(jump_masked),
      .jump_not_masked(jump_not_masked), .halted(halted),
      .waiting(waiting));

   npic_cpu_model cpu_model (
      .ref_clk(ref_clk), .resetn(resetn), .stall(stall), .take(take),
      .insn_end(insn_end));

   // Free-running 25 MHz clock.
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   // One-cycle register write.
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : bus_wr

   // One-cycle register read; data is looked at in the next cycle.
   task automatic bus_rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      `CHK("rdata", e, rdata)
   endtask : bus_rd

   // Reports one instruction; returns at the edge that samples it.
   task automatic do_op(input npic_op_e op, input logic [7:0] d);
      @(posedge ref_clk);
      cpu.op   <= op;
      cpu.data <= d;
      @(posedge ref_clk);
      cpu.op <= OP_NONE;
   endtask : do_op

   // Sets peripheral flags and enables, with a one-cycle clear pulse.
   task automatic src(input logic [13:0] f, input logic [13:0] e,
                      input logic [13:0] c);
      @(posedge ref_clk);
      periph_flag <= f;
      periph_en   <= e;
      periph_clr  <= c;
      @(posedge ref_clk);
      periph_clr <= '0;
   endtask : src

   // Waits, bounded, for the next entry and checks what it carries.
   task automatic wait_take(input logic [15:0] v, input logic [1:0] l,
                            input logic s);
      int n;
      n = 0;
      @(negedge ref_clk);
      while (take.valid !== 1'b1 && n < 60)
      begin
         @(negedge ref_clk);
         n++;
      end
      if (take.valid !== 1'b1)
      begin
         miscompares++;
         give_verdict();
      end
      else
      begin
         `CHK("vector", v, take.vector)
         `CHK("level", l, take.level)
         `CHK("stack", s, take.stack)
      end
   endtask : wait_take

   // Checks that no entry is made for n cycles.
   task automatic no_take(input int n);
      repeat (n)
      begin
         @(negedge ref_clk);
         `CHK("no entry", 1'b0, take.valid)
      end
   endtask : no_take

   ////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      resetn = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      cpu = '{op: OP_NONE, data: 8'h00};
      ext_pin = '0;
      periph_flag = '0;
      periph_en = '0;
      periph_clr = '0;
      stall = 1'b0;
      miscompares = 0;
      cmp_count = 0;
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      wait_take(VEC_RESET, LVL3, 1'b0);
      `CHK("codes", CODES_RST, cpu_codes)
      `CHK("jump masked", 1'b1, jump_masked)
      for (i = 0; i < 4; i++)
         bus_rd(ADDR_PRIO0 + i[3:0], PRIO_RST);
      for (i = 0; i < 11; i++)
      begin
         bus_wr(rows[i].a, rows[i].d);
         bus_rd(rows[i].a, rows[i].e);
      end
      `CHK("jump not masked", 1'b1, jump_not_masked)
      // Software level first, then hardware order.
      do_op(OP_DISABLE, 8'h00);
      #1 `CHK("codes", 8'he8, cpu_codes)
      src(14'h2002, 14'h2002, 14'h0000);
      no_take(5);
      do_op(OP_ENABLE, 8'h00);
      wait_take(16'hffe0, 2'b00, 1'b1);
      no_take(8);
      src(14'h0002, 14'h0002, 14'h2000);
      do_op(OP_POP_CODES, 8'h20);
      wait_take(16'hfff8, 2'b01, 1'b1);
      src(14'h0600, 14'h0600, 14'h0002);
      do_op(OP_POP_CODES, 8'h20);
      wait_take(16'hffe8, 2'b01, 1'b1);
      src(14'h0000, 14'h0000, 14'h0600);
      do_op(OP_POP_CODES, 8'h20);
      no_take(10);
      src(14'h0400, 14'h0000, 14'h0000);
      no_take(10);
      do_op(OP_DISABLE, 8'h00);
      do_op(OP_TRAP, 8'h00);
      wait_take(VEC_TRAP, LVL3, 1'b1);
      // Halt: only a capable source wakes, the other follows at the next boundary.
      do_op(OP_HALT, 8'h00);
      #1 `CHK("halt level", LVL0, {cpu_codes[5], cpu_codes[3]})
      `CHK("halted", 1'b1, halted)
      src(14'h0500, 14'h0100, 14'h0000);
      no_take(10);
      @(posedge ref_clk) ext_pin[5] <= 1'b1;
      wait_take(16'hfff4, 2'b01, 1'b1);
      `CHK("halted", 1'b0, halted)
      wait_take(16'hffea, 2'b11, 1'b1);
      bus_rd(ADDR_PEND_LO, 8'h00);
      bus_rd(ADDR_PEND_HI, 8'h01);
      src(14'h0000, 14'h0000, 14'h0100);
      do_op(OP_POP_CODES, 8'h20);
      // Each rising pin edge of a group triggers the shared line.
      @(posedge ref_clk) ext_pin[4] <= 1'b1;
      wait_take(16'hfff4, 2'b01, 1'b1);
      @(posedge ref_clk) ext_pin[5:4] <= 2'b00;
      do_op(OP_POP_CODES, 8'h20);
      no_take(10);
      @(posedge ref_clk) ext_pin[4] <= 1'b1;
      wait_take(16'hfff4, 2'b01, 1'b1);
      // Wait mode is left by any source.
      do_op(OP_POP_CODES, 8'h20);
      do_op(OP_WAIT, 8'h00);
      #1 `CHK("waiting", 1'b1, waiting)
      src(14'h0400, 14'h0400, 14'h0000);
      wait_take(16'hffe6, 2'b01, 1'b1);
      `CHK("waiting", 1'b0, waiting)
      src(14'h0000, 14'h0000, 14'h0400);
      // Entry only at an instruction boundary.
      do_op(OP_POP_CODES, 8'h20);
      @(posedge ref_clk) stall <= 1'b1;
      src(14'h0800, 14'h0800, 14'h0000);
      no_take(10);
      @(posedge ref_clk) stall <= 1'b0;
      wait_take(16'hffe4, 2'b01, 1'b1);
      src(14'h0000, 14'h0000, 14'h0800);
      // Reset leaves halt whatever the level.
      do_op(OP_HALT, 8'h00);
      @(posedge ref_clk) resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      wait_take(VEC_RESET, LVL3, 1'b0);
      `CHK("halted", 1'b0, halted)
      `CHK("codes", CODES_RST, cpu_codes)
      give_verdict();
   end
endmodule : npic_core_tb_top
